// ### shared/uart_port_flow_baud_ctrl_params.svh
// Constants of the port, flow-control and baud logic
// Assumes inclusion by the package and the design file only
`ifndef UART_PORT_FLOW_BAUD_CTRL_PARAMS_SVH
`define UART_PORT_FLOW_BAUD_CTRL_PARAMS_SVH

// ==========================================================
// Clock and baud division
`define CLK_HZ 200000000
`define BAUD_DIV(r10) ((`CLK_HZ * 10) / (16 * (r10)))
`define DIV_W 20
`define DIV_ONE 20'h00001
`define DIV_ZERO 20'h00000

// ==========================================================
// Register indices (byte address is four times the index)
`define IDX_MODE1 4'h0
`define IDX_MODE2 4'h1
`define IDX_TEST 4'h2
`define IDX_CSR 4'h3
`define IDX_CMD 4'h4
`define IDX_ACR 4'h5
`define IDX_OUTPUT_CONFIG_REG 4'h6
`define IDX_STATUS 4'h7
`define IDX_TXHOLD 4'h8
`define IDX_LATCH 4'h9
`define IDX_BRGTEST 4'hA
`define IDX_SETBITS 4'hE
`define IDX_CLRBITS 4'hF
`define ADDR_HI_ZERO 2'h0
`define ADDR_LO_ZERO 2'h0

// ==========================================================
// Field positions
`define M1_RX_RTS 7
`define M1_MODE_HI 4
`define M1_MODE_LO 3
`define M1_WAKEUP 2'h3
`define M2_TX_RTS 5
`define M2_CTS_EN 4
`define ACR_RATE_SET 7
`define CMD_RX_EN 0
`define CMD_RX_DIS 1
`define CMD_TX_EN 2
`define CMD_TX_DIS 3
`define CMD_MISC_HI 7
`define CMD_MISC_LO 4
`define CMD_RX_RESET 4'h2
`define CMD_RTS_ON 4'h8
`define CMD_RTS_OFF 4'h9

// ==========================================================
// Clock-select codes
`define CS_TIMER 4'hD
`define CS_EXT16 4'hE
`define CS_EXT1 4'hF

// ==========================================================
// Transmitter timing in ticks
`define ARM_16X 4'h4
`define ARM_1X 4'h2
`define BIT_16X 4'hF
`define BIT_1X 4'h0
`define LAST_DATA_BIT 3'h7

// ==========================================================
// Reset values
`define RST_PINS 8'hFF
`define RST_BYTE 8'h00
`define RST_WORD 32'h0000_0000
`endif

// ### shared/uart_port_flow_baud_ctrl_pkg.sv
// Types of the port, flow-control and baud logic
// Assumes the params header is on the include path
`include "uart_port_flow_baud_ctrl_params.svh"
package uart_port_flow_baud_ctrl_pkg;

  // ==========================================================
  // Bus carriers
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } apb_rsp_t;

  // ==========================================================
  // Transmitter states
  typedef enum logic [4:0] {
    TX_IDLE = 5'b00001,
    TX_ARM = 5'b00010,
    TX_START = 5'b00100,
    TX_DATA = 5'b01000,
    TX_STOP = 5'b10000
  } tx_state_t;

  // ==========================================================
  // Module state
  typedef struct packed {
    logic [`DIV_W-1:0] cnt;
    logic tick;
    logic x1;
  } baud_state_t;

  typedef struct packed {
    apb_rsp_t rsp;
    logic [7:0] mode1;
    logic [7:0] mode2;
    logic [7:0] clock_select_reg;
    logic [7:0] aux_control_reg;
    logic [7:0] output_config_reg;
    logic [7:0] latch;
    logic test1x;
    logic brg_test;
    logic tx_en;
    logic rx_en;
    logic rx_reset;
    logic [7:0] hold;
    logic hold_full;
    logic [7:0] shift;
    logic [3:0] sub;
    logic [2:0] bitcnt;
    tx_state_t tx_state;
    logic tx_line;
    logic rx_rts;
    logic [7:0] pins;
    logic cts_s1;
    logic cts_s2;
    logic ext_s1;
    logic ext_s2;
    logic ext_s3;
  } ctrl_state_t;

endpackage

// ### rtl/uart_port_flow_baud_ctrl.sv
// Output port, flow control, transmitter and baud selection of one serial channel
// Assumes an APB master on clk_sys; receiver FIFO status and timer tick on clk_sys
//
// Overview of operation
// RQ1: Pins two to seven take source from output_config_reg; pins zero, one from mode/command; here pin one follows only latch bit one.
// RQ2: A pin driven from output_port_latch shows the inverse of its latch bit.
// RQ3: Set-bits at E and clear-bits at F touch only positions holding ones.
// RQ4: With CTS enabled and clear_to_send_n high, finish current character then hold.
// RQ5: With CTS enable zero, clear_to_send_n has no effect on the transmitter.
// RQ6: Receiver raises ready_to_send_n when FIFO full and fourth start bit seen.
// RQ7: mode_reg_one bit 7 hands multipurpose_out_zero to receiver as ready-to-send.
// RQ8: Transmitter may drive pin zero as done flag; both owners together allowed.
// RQ9: Command codes 1000 and 1001 assert and negate ready-to-send by software.
// RQ10: Pin zero is NAND of latch bit zero and generated ready-to-send.
// RQ11: Flow control leaves latch bit zero alone; disabling returns pin to latch.
// RQ12: Disable within 3/16 bit (16x) or one bit (1x) after load sends nothing.
// RQ13: Underrun, one load, immediate disable: that character is not sent.
// RQ14: tx_empty_flag is set in underrun or just after enable.
// RQ15: Holding data moves to shift register in start bit; ready sets at its end.
// RQ16: Access at index 2 forces 1x clocking and routes internal nodes to pins.
// RQ17: Each read at index A toggles the alternate baud table for all channels.
// RQ18: Four-bit code and rate-set pick baud; 1101 timer, 1110 pin 16x, 1111 pin 1x.
// RQ19: Software resets receiver by reset then enable; mode registers stay intact.
// RQ20: In wake-up mode reset and disable are bypassed; software leaves mode first.
// RQ21: clear_to_send_n is synchronised before it gates transmission.
//
// Chosen here: the register addresses and the APB slave port.
`timescale 1ns/1ps
`include "uart_port_flow_baud_ctrl_params.svh"

// ==========================================================
// Baud tick generator
module baud_tick_gen
  import uart_port_flow_baud_ctrl_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic [3:0] code,
  input wire logic rate_set,
  input wire logic brg_test,
  input wire logic force_x1,
  input wire logic timer_tick,
  input wire logic ext_rise,
  output logic tick,
  output logic x1
);

  baud_state_t s_q;
  baud_state_t s_d;
  logic [`DIV_W-1:0] div;

  function automatic int unsigned rate_div(input logic [3:0] c, input logic set, input logic tst);
    int unsigned d;
    d = `BAUD_DIV(96000);
    unique case (c)
      4'h0: d = tst ? (set ? `BAUD_DIV(72000) : `BAUD_DIV(48000)) : (set ? `BAUD_DIV(750) : `BAUD_DIV(500));
      4'h1: d = tst ? `BAUD_DIV(8800) : `BAUD_DIV(1100);
      4'h2: d = tst ? `BAUD_DIV(10760) : `BAUD_DIV(1345);
      4'h3: d = tst ? (set ? `BAUD_DIV(144000) : `BAUD_DIV(192000)) : (set ? `BAUD_DIV(1500) : `BAUD_DIV(2000));
      4'h4: d = tst ? `BAUD_DIV(288000) : `BAUD_DIV(3000);
      4'h5: d = tst ? `BAUD_DIV(576000) : `BAUD_DIV(6000);
      4'h6: d = tst ? `BAUD_DIV(1152000) : `BAUD_DIV(12000);
      4'h7: d = set ? `BAUD_DIV(20000) : `BAUD_DIV(10500);
      4'h8: d = tst ? `BAUD_DIV(576000) : `BAUD_DIV(24000);
      4'h9: d = `BAUD_DIV(48000);
      4'hA: d = tst ? (set ? `BAUD_DIV(144000) : `BAUD_DIV(576000)) : (set ? `BAUD_DIV(18000) : `BAUD_DIV(72000));
      4'hB: d = `BAUD_DIV(96000);
      4'hC: d = set ? `BAUD_DIV(192000) : `BAUD_DIV(384000);
      default: d = `BAUD_DIV(96000);
    endcase
    return d;
  endfunction

  assign div = `DIV_W'(rate_div(code, rate_set, brg_test)); // [RQ17]

  always_comb begin
    s_d = s_q;
    s_d.x1 = force_x1 | (code == `CS_EXT1); // [RQ16] [RQ18]
    s_d.tick = 1'b0;
    unique case (code)
      `CS_TIMER: s_d.tick = timer_tick; // [RQ18]
      `CS_EXT16, `CS_EXT1: s_d.tick = ext_rise; // [RQ18]
      default: begin
        if (s_q.cnt >= div - `DIV_ONE) begin
          s_d.cnt = `DIV_ZERO;
          s_d.tick = 1'b1;
        end else begin
          s_d.cnt = s_q.cnt + `DIV_ONE;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign tick = s_q.tick;
  assign x1 = s_q.x1;

endmodule // baud_tick_gen

// ==========================================================
// Top level
module uart_port_flow_baud_ctrl
  import uart_port_flow_baud_ctrl_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset_n,
  input apb_req_t apb_req,
  output apb_rsp_t apb_rsp,
  input wire logic clear_to_send_n,
  input wire logic ext_clock_pin,
  input wire logic timer_tick,
  input wire logic rx_fifo_full,
  input wire logic rx_start_detect,
  output logic [7:0] out_pins,
  output logic tx_serial_out,
  output logic rx_enable,
  output logic rx_reset,
  output logic rx_tick,
  output logic rx_x1,
  output logic test_mode
);

  localparam ctrl_state_t CTRL_RESET = '{
    tx_state: TX_IDLE,
    tx_line: 1'b1,
    rx_rts: 1'b1,
    pins: `RST_PINS,
    default: '0
  };

  ctrl_state_t s_q;
  ctrl_state_t s_d;
  logic tx_tick;
  logic tx_x1;
  logic ext_rise;
  logic [3:0] idx;
  logic addr_ok;
  logic setup;
  logic access;
  logic wr;
  logic rd;
  logic [3:0] misc;
  logic wakeup;
  logic cts_ok;
  logic tx_ready;
  logic tx_empty;
  logic rts_sig;
  logic [3:0] arm_lim;
  logic [3:0] bit_lim;
  logic [7:0] status;
  logic [7:0] nodes;

  // ==========================================================
  // Baud selection
  assign ext_rise = s_q.ext_s2 & ~s_q.ext_s3;

  baud_tick_gen tx_baud (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .code(s_q.clock_select_reg[7:4]),
    .rate_set(s_q.aux_control_reg[`ACR_RATE_SET]),
    .brg_test(s_q.brg_test),
    .force_x1(s_q.test1x),
    .timer_tick(timer_tick),
    .ext_rise(ext_rise),
    .tick(tx_tick),
    .x1(tx_x1)
  );

  baud_tick_gen rx_baud (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .code(s_q.clock_select_reg[3:0]),
    .rate_set(s_q.aux_control_reg[`ACR_RATE_SET]),
    .brg_test(s_q.brg_test),
    .force_x1(s_q.test1x),
    .timer_tick(timer_tick),
    .ext_rise(ext_rise),
    .tick(rx_tick),
    .x1(rx_x1)
  );

  // ==========================================================
  // Decode and status
  assign idx = apb_req.paddr[5:2];
  assign addr_ok = (apb_req.paddr[7:6] == `ADDR_HI_ZERO) && (apb_req.paddr[1:0] == `ADDR_LO_ZERO)
                   && (idx != 4'hB) && (idx != 4'hC) && (idx != 4'hD);
  assign setup = apb_req.psel & ~apb_req.penable;
  assign access = apb_req.psel & apb_req.penable & s_q.rsp.pready & addr_ok;
  assign wr = access & apb_req.pwrite;
  assign rd = access & ~apb_req.pwrite;
  assign misc = apb_req.pwdata[`CMD_MISC_HI:`CMD_MISC_LO];
  assign wakeup = (s_q.mode1[`M1_MODE_HI:`M1_MODE_LO] == `M1_WAKEUP);
  assign cts_ok = ~s_q.mode2[`M2_CTS_EN] | ~s_q.cts_s2; // [RQ4] [RQ5] [RQ21]
  assign tx_ready = ~s_q.hold_full;
  assign tx_empty = (s_q.tx_state == TX_IDLE) & ~s_q.hold_full; // [RQ14]
  assign rts_sig = (s_q.mode1[`M1_RX_RTS] ? s_q.rx_rts : 1'b1)
                   & (s_q.mode2[`M2_TX_RTS] ? ~tx_empty : 1'b1); // [RQ7] [RQ8]
  assign arm_lim = tx_x1 ? `ARM_1X : `ARM_16X;
  assign bit_lim = tx_x1 ? `BIT_1X : `BIT_16X;
  assign status = {1'b0, s_q.rx_rts, s_q.cts_s2, wakeup, tx_empty, tx_ready, s_q.rx_en, s_q.tx_en};
  assign nodes = {s_q.tx_state, tx_tick, s_q.tx_line, s_q.hold_full};

  // ==========================================================
  // Next state
  always_comb begin
    s_d = s_q;
    s_d.cts_s1 = clear_to_send_n;
    s_d.cts_s2 = s_q.cts_s1; // [RQ21]
    s_d.ext_s1 = ext_clock_pin;
    s_d.ext_s2 = s_q.ext_s1;
    s_d.ext_s3 = s_q.ext_s2;
    s_d.rx_reset = 1'b0;

    // Receiver flow control
    if (!rx_fifo_full) begin
      s_d.rx_rts = 1'b1;
    end else if (rx_start_detect) begin
      s_d.rx_rts = 1'b0; // [RQ6]
    end

    // Transmitter
    unique case (s_q.tx_state)
      TX_IDLE: begin
        s_d.tx_line = 1'b1;
        if (s_q.tx_en && s_q.hold_full && cts_ok) begin // [RQ4] [RQ5]
          s_d.tx_state = TX_ARM;
          s_d.sub = 4'h0;
        end
      end
      TX_ARM: begin
        if (!s_q.tx_en) begin
          s_d.hold_full = 1'b0; // [RQ12] [RQ13]
          s_d.tx_state = TX_IDLE;
        end else if (tx_tick) begin
          if (s_q.sub == arm_lim - 4'h1) begin // [RQ12]
            s_d.tx_state = TX_START;
            s_d.sub = 4'h0;
            s_d.shift = s_q.hold; // [RQ15]
            s_d.tx_line = 1'b0;
          end else begin
            s_d.sub = s_q.sub + 4'h1;
          end
        end
      end
      TX_START: begin
        if (tx_tick) begin
          if (s_q.sub == bit_lim) begin
            s_d.hold_full = 1'b0; // [RQ15]
            s_d.tx_state = TX_DATA;
            s_d.sub = 4'h0;
            s_d.bitcnt = 3'h0;
            s_d.tx_line = s_q.shift[0];
          end else begin
            s_d.sub = s_q.sub + 4'h1;
          end
        end
      end
      TX_DATA: begin
        if (tx_tick) begin
          if (s_q.sub == bit_lim) begin
            s_d.sub = 4'h0;
            s_d.shift = {1'b0, s_q.shift[7:1]};
            if (s_q.bitcnt == `LAST_DATA_BIT) begin
              s_d.tx_state = TX_STOP;
              s_d.tx_line = 1'b1;
            end else begin
              s_d.bitcnt = s_q.bitcnt + 3'h1;
              s_d.tx_line = s_q.shift[1];
            end
          end else begin
            s_d.sub = s_q.sub + 4'h1;
          end
        end
      end
      TX_STOP: begin
        if (tx_tick) begin
          if (s_q.sub == bit_lim) begin
            s_d.sub = 4'h0;
            s_d.tx_state = TX_IDLE;
          end else begin
            s_d.sub = s_q.sub + 4'h1;
          end
        end
      end
    endcase

    // Register writes
    if (wr) begin
      unique case (idx)
        `IDX_MODE1: s_d.mode1 = apb_req.pwdata[7:0];
        `IDX_MODE2: s_d.mode2 = apb_req.pwdata[7:0];
        `IDX_TEST: s_d.test1x = apb_req.pwdata[0]; // [RQ16]
        `IDX_CSR: s_d.clock_select_reg = apb_req.pwdata[7:0]; // [RQ18]
        `IDX_ACR: s_d.aux_control_reg = apb_req.pwdata[7:0];
        `IDX_OUTPUT_CONFIG_REG: s_d.output_config_reg = apb_req.pwdata[7:0];
        `IDX_LATCH: s_d.latch = apb_req.pwdata[7:0];
        `IDX_SETBITS: s_d.latch = s_q.latch | apb_req.pwdata[7:0]; // [RQ3]
        `IDX_CLRBITS: s_d.latch = s_q.latch & ~apb_req.pwdata[7:0]; // [RQ3]
        `IDX_TXHOLD: begin
          if (!s_d.hold_full) begin
            s_d.hold = apb_req.pwdata[7:0];
            s_d.hold_full = 1'b1;
          end
        end
        `IDX_CMD: begin
          if (apb_req.pwdata[`CMD_TX_EN]) begin
            s_d.tx_en = 1'b1;
          end
          if (apb_req.pwdata[`CMD_TX_DIS]) begin
            s_d.tx_en = 1'b0;
          end
          if (apb_req.pwdata[`CMD_RX_EN]) begin
            s_d.rx_en = 1'b1;
          end
          if (apb_req.pwdata[`CMD_RX_DIS] && !wakeup) begin
            s_d.rx_en = 1'b0; // [RQ20]
          end
          if (misc == `CMD_RX_RESET && !wakeup) begin
            s_d.rx_en = 1'b0; // [RQ19] [RQ20]
            s_d.rx_reset = 1'b1;
          end
          if (misc == `CMD_RTS_ON) begin
            s_d.latch[0] = 1'b1; // [RQ9]
          end
          if (misc == `CMD_RTS_OFF) begin
            s_d.latch[0] = 1'b0; // [RQ9]
          end
        end
        default: begin
        end
      endcase
    end
    if (rd && idx == `IDX_BRGTEST) begin
      s_d.brg_test = ~s_q.brg_test; // [RQ17]
    end

    // Output pins
    s_d.pins[0] = ~(s_d.latch[0] & rts_sig); // [RQ10] [RQ11]
    s_d.pins[1] = ~s_d.latch[1]; // [RQ1] [RQ2]
    for (int k = 2; k < 8; k++) begin
      s_d.pins[k] = s_q.test1x ? nodes[k] : (s_q.output_config_reg[k] ? status[k - 2] : ~s_d.latch[k]); // [RQ1] [RQ2] [RQ16]
    end

    // Bus answer
    s_d.rsp.pready = setup;
    if (setup) begin
      s_d.rsp.pslverr = ~addr_ok;
      s_d.rsp.prdata = `RST_WORD;
      unique case (idx)
        `IDX_MODE1: s_d.rsp.prdata[7:0] = s_q.mode1;
        `IDX_MODE2: s_d.rsp.prdata[7:0] = s_q.mode2;
        `IDX_TEST: s_d.rsp.prdata[0] = s_q.test1x;
        `IDX_CSR: s_d.rsp.prdata[7:0] = s_q.clock_select_reg;
        `IDX_ACR: s_d.rsp.prdata[7:0] = s_q.aux_control_reg;
        `IDX_OUTPUT_CONFIG_REG: s_d.rsp.prdata[7:0] = s_q.output_config_reg;
        `IDX_STATUS: s_d.rsp.prdata[7:0] = status;
        `IDX_LATCH: s_d.rsp.prdata[7:0] = s_q.latch;
        `IDX_BRGTEST: s_d.rsp.prdata[0] = s_q.brg_test;
        default: s_d.rsp.prdata = `RST_WORD;
      endcase
    end else if (!apb_req.psel) begin
      s_d.rsp.pslverr = 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      s_q <= CTRL_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================================
  // Outputs
  assign apb_rsp = s_q.rsp;
  assign out_pins = s_q.pins;
  assign tx_serial_out = s_q.tx_line;
  assign rx_enable = s_q.rx_en;
  assign rx_reset = s_q.rx_reset;
  assign test_mode = s_q.test1x;

endmodule // uart_port_flow_baud_ctrl

// ### tb/uart_port_flow_baud_ctrl_chk.sv
// Checker of the port, flow and baud control block
// Assumes binding to the top module; sees only its ports
`timescale 1ns/1ps
module uart_port_flow_baud_ctrl_chk
  import uart_port_flow_baud_ctrl_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset_n,
  input apb_req_t apb_req,
  input apb_rsp_t apb_rsp,
  input wire logic rx_fifo_full,
  input wire logic rx_start_detect,
  input logic [7:0] out_pins,
  input logic rx_x1,
  input logic test_mode
);
  // ==========================================================
  // Decode of completed transfers
  logic wr;
  logic rd;
  logic [7:0] wd;
  logic [7:0] ad;
  logic m17_q;
  logic m25_q;
  logic opz_q;
  logic brg_q;
  assign rd = apb_req.psel & apb_req.penable & apb_rsp.pready & !apb_req.pwrite;
  assign wr = apb_req.psel & apb_req.penable & apb_rsp.pready & apb_req.pwrite;
  assign wd = apb_req.pwdata[7:0];
  assign ad = apb_req.paddr;
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      m17_q <= 1'h0;
      m25_q <= 1'h0;
      opz_q <= 1'h1;
      brg_q <= 1'h1;
    end else begin
      if (wr && ad == 8'h00)
        m17_q <= wd[7];
      if (wr && ad == 8'h04)
        m25_q <= wd[5];
      if (wr && ad == 8'h18)
        opz_q <= wd[7:2] == 6'h00;
      if (rd && ad == 8'h28)
        brg_q <= apb_rsp.prdata[0];
    end
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!reset_n);
  chk_setup_ready: assert property (apb_req.psel && !apb_req.penable |=> apb_rsp.pready)
    else $error("no ready after setup");
  chk_set_bits: assert property (wr && ad == 8'h38 && opz_q && !test_mode |->
    ##2 (out_pins & $past(wd, 2) & 8'hFE) == 8'h00) else $error("set bits not low");
  chk_clr_bits: assert property (wr && ad == 8'h3C && opz_q && !test_mode |->
    ##2 (out_pins & $past(wd, 2) & 8'hFE) == ($past(wd, 2) & 8'hFE)) else $error("cleared bits not high");
  chk_keep_bits: assert property (wr && (ad == 8'h38 || ad == 8'h3C) && opz_q && !test_mode |->
    ##2 ((out_pins ^ $past(out_pins, 2)) & ~$past(wd, 2) & 8'hFE) == 8'h00) else $error("other bits moved");
  chk_test_x1: assert property (test_mode && $past(test_mode) |-> rx_x1)
    else $error("test mode without 1x");
  chk_ext_1x: assert property (wr && ad == 8'h0C && wd[3:0] == 4'hF && !test_mode |-> ##[1:3] rx_x1)
    else $error("code F not 1x");
  chk_brg_toggle: assert property (rd && ad == 8'h28 |-> apb_rsp.prdata[0] != brg_q)
    else $error("baud test did not toggle");
  chk_rts_on: assert property (wr && ad == 8'h10 && wd[7:4] == 4'h8 && !m17_q && !m25_q |->
    ##2 !out_pins[0]) else $error("rts on not low");
  chk_rx_flow: assert property (m17_q && !m25_q && !out_pins[0] && rx_fifo_full && rx_start_detect |->
    ##2 out_pins[0]) else $error("flow stop not high");
  cover property (wr && ad == 8'h20);
  cover property (m17_q && rx_fifo_full && rx_start_detect);
  cover property (rd && ad == 8'h28);
endmodule // uart_port_flow_baud_ctrl_chk

bind uart_port_flow_baud_ctrl uart_port_flow_baud_ctrl_chk i_uart_port_flow_baud_ctrl_chk (
  .clk_sys(clk_sys), .reset_n(reset_n), .apb_req(apb_req), .apb_rsp(apb_rsp),
  .rx_fifo_full(rx_fifo_full), .rx_start_detect(rx_start_detect), .out_pins(out_pins),
  .rx_x1(rx_x1), .test_mode(test_mode));

// ### tb/remote_serial_peer.sv
// Remote serial party: receives characters and drives clear-to-send
// Assumes 8N1 characters at 1x from the external clock it supplies
`timescale 1ns/1ps
module remote_serial_peer (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic busy,
  input wire logic line_in,
  output logic clear_to_send_n,
  output logic ext_clock_pin,
  output logic [7:0] rx_byte,
  output int rx_count
);
  logic [2:0] div_q;
  logic [6:0] cnt_q;
  logic on_q;
  logic [7:0] sh_q;
  assign clear_to_send_n = busy; // Remote receiver full holds the line high
  assign ext_clock_pin = div_q[2]; // Free 1x baud clock, 8 cycles a bit
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      div_q <= 3'h0;
      cnt_q <= 7'h00;
      on_q <= 1'h0;
      sh_q <= 8'h00;
      rx_byte <= 8'h00;
      rx_count <= 0;
    end else begin
      div_q <= div_q + 3'h1;
      cnt_q <= on_q ? cnt_q + 7'h01 : 7'h00;
      if (!on_q)
        on_q <= !line_in;
      else if (cnt_q[2:0] == 3'h3 && cnt_q[6:3] == 4'h9) begin
        rx_byte <= sh_q;
        rx_count <= rx_count + 1;
        on_q <= 1'h0;
      end else if (cnt_q[2:0] == 3'h3 && cnt_q[6:3] != 4'h0)
        sh_q <= {line_in, sh_q[7:1]};
    end
  end
endmodule // remote_serial_peer

// ### tb/tb_uart_port_flow_baud_ctrl.sv
// Testbench of the port, flow and baud control block
// Assumes the checker is bound and the peer supplies the external clock
`timescale 1ns/1ps
module tb_uart_port_flow_baud_ctrl
  import uart_port_flow_baud_ctrl_pkg::*;
;
  logic clk_sys = 1'h0;
  logic reset_n = 1'h0;
  apb_req_t req = '0;
  apb_rsp_t rsp;
  logic busy = 1'h0;
  logic full = 1'h0;
  logic start = 1'h0;
  logic tmr = 1'h0;
  logic cts_n, ext, txo, rxen, rxrst, rxx1, rxtk, tmode, er, got;
  logic [7:0] pins, rbyte;
  logic [31:0] rd;
  int nch, n_mismatch = 0, comparisons = 0, cyc = 0, nrst = 0;

  uart_port_flow_baud_ctrl i_uart_port_flow_baud_ctrl (.clk_sys(clk_sys), .reset_n(reset_n),
    .apb_req(req), .apb_rsp(rsp), .clear_to_send_n(cts_n), .ext_clock_pin(ext), .timer_tick(tmr),
    .rx_fifo_full(full), .rx_start_detect(start), .out_pins(pins), .tx_serial_out(txo),
    .rx_enable(rxen), .rx_reset(rxrst), .rx_tick(rxtk), .rx_x1(rxx1), .test_mode(tmode));
  remote_serial_peer i_remote_serial_peer (.clk_sys(clk_sys), .reset_n(reset_n), .busy(busy),
    .line_in(txo), .clear_to_send_n(cts_n), .ext_clock_pin(ext), .rx_byte(rbyte), .rx_count(nch));

  // ==========================================================
  // Clock, timeout and reset pulse count
  initial forever #2.5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cyc++;
    if (rxrst === 1'h1)
      nrst++;
    if (cyc == 30000) begin
      n_mismatch++;
      wrap_up();
    end
  end

  // ==========================================================
  // Shared tasks
  task wrap_up();
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    req.psel <= 1'h1;
    req.penable <= 1'h0;
    req.pwrite <= w;
    req.paddr <= a;
    req.pwdata <= {24'h000000, d};
    @(posedge clk_sys);
    req.penable <= 1'h1;
    @(posedge clk_sys);
    while (rsp.pready !== 1'h1) @(posedge clk_sys);
    rd = rsp.prdata;
    er = rsp.pslverr;
    req.psel <= 1'h0;
    req.penable <= 1'h0;
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'h1, a, d);
  endtask
  task wt(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task char_wait();
    int n0;
    n0 = nch;
    got = 1'h0;
    for (int i = 0; i < 300 && !got; i++) begin
      @(posedge clk_sys);
      got = nch != n0;
    end
  endtask

  // ==========================================================
  // Scenarios
  task t_port();
    check({txo, tmode, pins}, 32'h2FF);
    wr(8'h38, 8'h22);
    wt(2);
    check(pins, 32'hDD);
    wr(8'h3C, 8'h20);
    wt(2);
    check(pins, 32'hFD);
    apb(1'h0, 8'h24, 8'h00);
    check(rd, 32'h02);
    wr(8'h18, 8'h04);
    wt(2);
    check(pins, 32'hF9);
    wr(8'h18, 8'h00);
  endtask
  task t_rts();
    wr(8'h10, 8'h80);
    wt(2);
    check(pins[0], 32'h0);
    wr(8'h10, 8'h90);
    wt(2);
    check(pins[0], 32'h1);
    wr(8'h10, 8'h80);
    wr(8'h00, 8'h80);
    wt(2);
    check(pins[0], 32'h0);
    full <= 1'h1;
    start <= 1'h1;
    wt(1);
    start <= 1'h0;
    wt(3);
    check(pins[0], 32'h1);
    apb(1'h0, 8'h24, 8'h00);
    check(rd[0], 32'h1);
    full <= 1'h0;
    wr(8'h00, 8'h00);
    wt(2);
    check(pins[0], 32'h0);
    wr(8'h04, 8'h20);
    wt(2);
    check(pins[0], 32'h1);
    wr(8'h04, 8'h00);
  endtask
  task t_tx();
    wr(8'h0C, 8'hF0);
    wr(8'h10, 8'h04);
    apb(1'h0, 8'h1C, 8'h00);
    check(rd[3], 32'h1);
    wr(8'h20, 8'hA5);
    char_wait();
    check({got, rbyte}, 32'h1A5);
    wt(8);
    apb(1'h0, 8'h1C, 8'h00);
    check(rd[3:2], 32'h3);
  endtask
  task t_cts();
    wr(8'h04, 8'h10);
    busy <= 1'h1;
    wt(4);
    wr(8'h20, 8'h3C);
    char_wait();
    check(got, 32'h0);
    busy <= 1'h0;
    char_wait();
    check({got, rbyte}, 32'h13C);
    wr(8'h04, 8'h00);
    busy <= 1'h1;
    wr(8'h20, 8'h5A);
    char_wait();
    check({got, rbyte}, 32'h15A);
    busy <= 1'h0;
  endtask
  task t_dis();
    wr(8'h0C, 8'hE0);
    wr(8'h20, 8'h77);
    wr(8'h10, 8'h08);
    char_wait();
    check(got, 32'h0);
    wr(8'h0C, 8'hF0);
    wr(8'h10, 8'h04);
    wr(8'h20, 8'h66);
    wr(8'h10, 8'h08);
    char_wait();
    check(got, 32'h0);
  endtask
  task t_baud();
    for (int i = 0; i < 3; i++) begin
      apb(1'h0, 8'h28, 8'h00);
      check(rd[0], i % 2);
    end
    apb(1'h0, 8'h28, 8'h00);
    apb(1'h0, 8'h2C, 8'h00);
    check(rd, 32'h0);
    check({31'h0, er}, 32'h1);
    wr(8'h08, 8'h01);
    wt(2);
    check({tmode, rxx1}, 32'h3);
    wr(8'h08, 8'h00);
    wr(8'h0C, 8'hFF);
    wt(3);
    check(rxx1, 32'h1);
    wr(8'h0C, 8'hFE);
    wt(3);
    check({tmode, rxx1}, 32'h0);
    wr(8'h0C, 8'hFD);
    wt(2);
    check(rxtk, 32'h0);
    tmr <= 1'h1;
    wt(1);
    tmr <= 1'h0;
    wt(1);
    check(rxtk, 32'h1);
  endtask
  task t_rxrst();
    int n0;
    wr(8'h10, 8'h01);
    n0 = nrst;
    wr(8'h10, 8'h20);
    wr(8'h10, 8'h01);
    wt(2);
    check({rxen, 8'(nrst - n0)}, 32'h101);
    wr(8'h00, 8'h18);
    wr(8'h10, 8'h20);
    wt(2);
    check(nrst - n0, 32'h1);
    wr(8'h00, 8'h10);
    wr(8'h10, 8'h20);
    wr(8'h00, 8'h18);
    apb(1'h0, 8'h00, 8'h00);
    check({rd[7:0], 8'(nrst - n0)}, 32'h1802);
  endtask

  initial begin
    wt(5);
    reset_n <= 1'h1;
    wt(1);
    t_port();
    t_rts();
    t_tx();
    t_cts();
    t_dis();
    t_baud();
    t_rxrst();
    wrap_up();
  end
endmodule // tb_uart_port_flow_baud_ctrl
